// File: pkg/dlef_pkg.sv
package dlef_pkg;
    // Bit positions in the low status byte
    localparam int unsigned OVR_BIT = 4;
    localparam int unsigned NRS_BIT = 3;
    localparam int unsigned RIV_BIT = 2;
    localparam logic [7:0] SUBST_BYTE = 8'hee;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    // Free-cycle wait limit in core clock cycles
    localparam int unsigned STEAL_TIMEOUT = 512;
    localparam int unsigned TMO_W = 10;
    localparam logic [TMO_W-1:0] TMO_ZERO = 10'h000;
    localparam logic [TMO_W-1:0] TMO_ONE = 10'h001;
    localparam logic [TMO_W-1:0] TMO_LAST = 10'(STEAL_TIMEOUT - 1);

    typedef enum logic [1:0]
    {
        ACC_IDLE = 2'b00,
        ACC_WAIT = 2'b01,
        ACC_BUSY = 2'b10
    } dlef_acc_t;
endpackage

// File: src/dlef_flags.sv
// Notes on behaviour
// - Set overrun when a new command arrives before the current one completes.
// - With acknowledge on, host pulling pin low during pending acknowledge sets overrun.
// - While overrun is set, all debug internal accesses are suppressed.
// - Host resynchronisation pulse clears overrun; host must send it to recover.
// - With acknowledge on and stealing off, no free cycle in 512 sets no-response.
// - Acknowledge off or stealing on: unfinished access at retrieval, or unfinished write at next command, sets no-response.
// - Memory or pc-sample access in stop with continue-in-stop clear sets no-response.
// - Timeout, retrieval or next-command cases abort the access unless wait-stretch holds it; stop cases never start it.
// - Enter-debug command in wait sets no-response, not aborted, completes on wait exit.
// - In wait, each later CPU register access sets no-response again if cleared.
// - Any command while awaiting return from wait sets no-response.
// - Single-step while entering wait with controller enabled sets no-response.
// - While no-response is set, every data byte of that access reads 0xEE.
// - Writing one to bit 3 or bit 2 clears only that flag.
// - Debug read hitting an ECC error sets read-invalid.
// - A read-invalid read still returns the actual data read.
// - Stealing clear with acknowledge waits for a free cycle; set uses the next cycle.
// - Continue-in-stop clear keeps only the serial clock in stop; set keeps all.
// - Overrun set: later acknowledges are long once a whole byte follows the edge.
`timescale 1ns/1ps
`default_nettype none
module dlef_flags
    import dlef_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Host link events, from the serial decoder
    input wire logic cmd_start,
    input wire logic cmd_is_enter_debug,
    input wire logic cmd_is_cpu_reg,
    input wire logic cmd_is_step,
    input wire logic cmd_is_mem,
    input wire logic cmd_is_pc_sample,
    input wire logic host_pin_low,
    input wire logic ack_pending,
    input wire logic byte_received,
    input wire logic resync_pulse,
    input wire logic retrieve_start,
    // Controls
    input wire logic ack_enable,
    input wire logic steal_enable,
    input wire logic continue_in_stop_ctrl,
    input wire logic controller_enable,
    // Core status
    input wire logic stop_mode,
    input wire logic wait_mode,
    input wire logic wait_return_pending,
    input wire logic entering_wait,
    // Internal access port
    input wire logic acc_req,
    input wire logic acc_write,
    input wire logic bus_free,
    input wire logic acc_done,
    input wire logic ecc_error,
    input wire logic external_wait_stretch,
    input wire logic [7:0] rd_data,
    output logic acc_go,
    output logic acc_abort,
    output logic enter_debug_req,
    // Status byte access
    input wire logic status_wr,
    input wire logic [7:0] status_wdata,
    output logic [7:0] debug_status_low,
    // Data returned toward the host
    output logic [7:0] host_data,
    output logic long_ack
);
    typedef struct packed
    {
        logic overrun_flag;
        logic no_response_flag;
        logic read_invalid_flag;
        logic ovr_from_edge;
        logic ovr_byte_seen;
        logic enter_pending;
        logic abort_pending;
        logic acc_write_q;
        dlef_acc_t acc;
        logic [TMO_W-1:0] tmo;
        logic [7:0] host_data;
    } dlef_state_t;

    dlef_state_t st;
    dlef_state_t next_st;

    logic busy;
    logic set_ovr;
    logic set_nrs;
    logic kill;
    logic stop_block;

    always_comb
    begin
        next_st = st;
        busy = (st.acc != ACC_IDLE);
        // Immediate mode is acknowledge off or stealing on
        stop_block = stop_mode && !continue_in_stop_ctrl && (cmd_is_mem || cmd_is_pc_sample);
        set_ovr = (cmd_start && busy)
            || (ack_enable && host_pin_low && ack_pending);
        set_nrs = 1'b0;
        kill = 1'b0;
        if (busy && ack_enable && !steal_enable && st.acc == ACC_WAIT && st.tmo == TMO_LAST)
        begin
            set_nrs = 1'b1;
            kill = 1'b1;
        end
        if (busy && (!ack_enable || steal_enable)
            && (retrieve_start || (cmd_start && st.acc_write_q)))
        begin
            set_nrs = 1'b1;
            kill = 1'b1;
        end
        if (acc_req && stop_block)
        begin
            set_nrs = 1'b1;
        end
        if (cmd_start && cmd_is_enter_debug && wait_mode)
        begin
            set_nrs = 1'b1;
            next_st.enter_pending = 1'b1;
        end
        if (cmd_start && cmd_is_cpu_reg && wait_mode)
        begin
            set_nrs = 1'b1;
        end
        if (cmd_start && wait_return_pending)
        begin
            set_nrs = 1'b1;
        end
        if (cmd_start && cmd_is_step && controller_enable && entering_wait)
        begin
            set_nrs = 1'b1;
        end
        if (st.enter_pending && !wait_mode)
        begin
            next_st.enter_pending = 1'b0;
        end
        // Access sequencing; overrun blocks new starts
        case (st.acc)
            ACC_IDLE:
            begin
                next_st.tmo = TMO_ZERO;
                if (acc_req && !st.overrun_flag && !stop_block)
                begin
                    next_st.acc_write_q = acc_write;
                    next_st.acc = (ack_enable && !steal_enable) ? ACC_WAIT : ACC_BUSY;
                end
            end
            ACC_WAIT:
            begin
                next_st.tmo = st.tmo + TMO_ONE;
                if (bus_free)
                begin
                    next_st.acc = ACC_BUSY;
                end
            end
            ACC_BUSY:
            begin
                if (acc_done)
                begin
                    next_st.acc = ACC_IDLE;
                    next_st.host_data = st.no_response_flag ? SUBST_BYTE : rd_data;
                    if (!st.acc_write_q && ecc_error)
                    begin
                        next_st.read_invalid_flag = 1'b1;
                    end
                end
            end
            default:
            begin
                next_st.acc = ACC_IDLE;
            end
        endcase
        // Stretched external access aborts only after release
        if (kill || st.abort_pending)
        begin
            if (external_wait_stretch && st.acc == ACC_BUSY)
            begin
                next_st.abort_pending = 1'b1;
            end
            else
            begin
                next_st.abort_pending = 1'b0;
                next_st.acc = ACC_IDLE;
                next_st.host_data = SUBST_BYTE;
            end
        end
        // Host clears first, then hardware sets win
        if (status_wr && status_wdata[NRS_BIT])
        begin
            next_st.no_response_flag = 1'b0;
        end
        if (status_wr && status_wdata[RIV_BIT])
        begin
            next_st.read_invalid_flag = 1'b0;
        end
        if (set_nrs)
        begin
            next_st.no_response_flag = 1'b1;
        end
        if (st.acc == ACC_BUSY && acc_done && !st.acc_write_q && ecc_error)
        begin
            next_st.read_invalid_flag = 1'b1;
        end
        if (resync_pulse)
        begin
            next_st.overrun_flag = 1'b0;
            next_st.ovr_from_edge = 1'b0;
            next_st.ovr_byte_seen = 1'b0;
        end
        else if (byte_received && st.ovr_from_edge)
        begin
            next_st.ovr_byte_seen = 1'b1;
        end
        if (set_ovr)
        begin
            next_st.overrun_flag = 1'b1;
            if (!st.overrun_flag)
            begin
                next_st.ovr_from_edge = !(cmd_start && busy);
                next_st.ovr_byte_seen = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    always_comb
    begin
        debug_status_low = ZERO_BYTE;
        debug_status_low[OVR_BIT] = st.overrun_flag;
        debug_status_low[NRS_BIT] = st.no_response_flag;
        debug_status_low[RIV_BIT] = st.read_invalid_flag;
    end

    assign acc_go = (st.acc == ACC_BUSY) && !st.overrun_flag && !st.abort_pending;
    assign acc_abort = (kill || st.abort_pending) && !(external_wait_stretch && st.acc == ACC_BUSY);
    assign enter_debug_req = st.enter_pending && !wait_mode;
    assign host_data = st.host_data;
    // Edge-caused overrun holds off the long ack so it cannot collide with host bits
    assign long_ack = st.overrun_flag && (!st.ovr_from_edge || st.ovr_byte_seen);

    property p_ovr_set;
        @(posedge clk) disable iff (!nrst)
        (cmd_start && busy && !resync_pulse) |=> st.overrun_flag;
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("overrun not set on early command");

    property p_ovr_edge;
        @(posedge clk) disable iff (!nrst)
        (ack_enable && host_pin_low && ack_pending) |=> st.overrun_flag;
    endproperty
    a_ovr_edge: assert property (p_ovr_edge) else $error("overrun not set on ack collision");

    property p_suppress;
        @(posedge clk) disable iff (!nrst)
        st.overrun_flag |-> !acc_go;
    endproperty
    a_suppress: assert property (p_suppress) else $error("access ran during overrun");

    property p_resync;
        @(posedge clk) disable iff (!nrst)
        (resync_pulse && !set_ovr) |=> !st.overrun_flag;
    endproperty
    a_resync: assert property (p_resync) else $error("resync did not clear overrun");

    sequence s_wait_full;
        st.acc == ACC_WAIT && st.tmo == TMO_LAST && ack_enable && !steal_enable;
    endsequence
    property p_timeout;
        @(posedge clk) disable iff (!nrst)
        s_wait_full |=> st.no_response_flag && st.acc == ACC_IDLE ##0 st.host_data == SUBST_BYTE;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout did not flag and abort");

    property p_subst;
        @(posedge clk) disable iff (!nrst)
        (st.acc == ACC_BUSY && acc_done && st.no_response_flag && !kill) |=> host_data == SUBST_BYTE;
    endproperty
    a_subst: assert property (p_subst) else $error("substitute byte missing");

    property p_clear_one;
        @(posedge clk) disable iff (!nrst)
        (status_wr && status_wdata[RIV_BIT] && !status_wdata[NRS_BIT] && !set_nrs && st.no_response_flag)
        |=> st.no_response_flag;
    endproperty
    a_clear_one: assert property (p_clear_one) else $error("wrong flag cleared");

    property p_sticky;
        @(posedge clk) disable iff (!nrst)
        (st.no_response_flag && !(status_wr && status_wdata[NRS_BIT])) |=> st.no_response_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("no-response dropped");

    property p_real_data;
        @(posedge clk) disable iff (!nrst)
        (st.acc == ACC_BUSY && acc_done && ecc_error && !st.acc_write_q && !st.no_response_flag && !kill
            && !st.abort_pending)
        |=> st.read_invalid_flag && host_data == $past(rd_data);
    endproperty
    a_real_data: assert property (p_real_data) else $error("read-invalid data wrong");

    sequence s_stretched_kill;
        kill && external_wait_stretch && st.acc == ACC_BUSY;
    endsequence
    property p_abort_wait;
        @(posedge clk) disable iff (!nrst)
        s_stretched_kill |-> !acc_abort ##1 st.abort_pending;
    endproperty
    a_abort_wait: assert property (p_abort_wait) else $error("stretched access aborted early");

    property p_immediate;
        @(posedge clk) disable iff (!nrst)
        (busy && (!ack_enable || steal_enable) && retrieve_start) |=> st.no_response_flag;
    endproperty
    a_immediate: assert property (p_immediate) else $error("early retrieval not flagged");

    property p_enter_wait;
        @(posedge clk) disable iff (!nrst)
        (cmd_start && cmd_is_enter_debug && wait_mode) |=> st.no_response_flag && st.enter_pending;
    endproperty
    a_enter_wait: assert property (p_enter_wait) else $error("enter in wait not held");

    property p_long_delay;
        @(posedge clk) disable iff (!nrst)
        (ack_enable && host_pin_low && ack_pending && !st.overrun_flag && !cmd_start)
        |=> st.overrun_flag && !long_ack;
    endproperty
    a_long_delay: assert property (p_long_delay) else $error("long ack too early");
endmodule // dlef_flags
`default_nettype wire

// File: verification/debug_link_error_flags_bench.sv
`timescale 1ns/1ps
`default_nettype none
module debug_link_error_flags_bench;
    import dlef_pkg::*;
    logic clk = 0, nrst = 0, cmd_start = 0, cmd_is_enter_debug = 0, cmd_is_cpu_reg = 0, cmd_is_step = 0;
    logic cmd_is_mem = 0, cmd_is_pc_sample = 0, host_pin_low = 0, ack_pending = 0, byte_received = 0;
    logic resync_pulse = 0, retrieve_start = 0, ack_enable = 1, steal_enable = 0, continue_in_stop_ctrl = 0;
    logic controller_enable = 1, stop_mode = 0, wait_mode = 0, wait_return_pending = 0, entering_wait = 0;
    logic acc_req = 0, acc_write = 0, status_wr = 0, stall = 0, ecc_inj = 0, ews = 0;
    logic [7:0] status_wdata = 8'h00, data = 8'h00, rd_data, debug_status_low, host_data;
    logic bus_free, acc_done, ecc_error, acc_go, acc_abort, enter_debug_req, long_ack;
    logic [31:0] seed = 32'h6;
    int n_errors = 0, comparisons = 0, cycles = 0, k;
    logic riv;
    always #2 clk = ~clk;
    dlef_flags DUT (.clk(clk), .nrst(nrst), .cmd_start(cmd_start), .cmd_is_enter_debug(cmd_is_enter_debug),
        .cmd_is_cpu_reg(cmd_is_cpu_reg), .cmd_is_step(cmd_is_step), .cmd_is_mem(cmd_is_mem),
        .cmd_is_pc_sample(cmd_is_pc_sample), .host_pin_low(host_pin_low), .ack_pending(ack_pending),
        .byte_received(byte_received), .resync_pulse(resync_pulse), .retrieve_start(retrieve_start),
        .ack_enable(ack_enable), .steal_enable(steal_enable), .continue_in_stop_ctrl(continue_in_stop_ctrl),
        .controller_enable(controller_enable), .stop_mode(stop_mode), .wait_mode(wait_mode),
        .wait_return_pending(wait_return_pending), .entering_wait(entering_wait), .acc_req(acc_req),
        .acc_write(acc_write), .bus_free(bus_free), .acc_done(acc_done), .ecc_error(ecc_error),
        .external_wait_stretch(ews), .rd_data(rd_data), .acc_go(acc_go), .acc_abort(acc_abort),
        .enter_debug_req(enter_debug_req), .status_wr(status_wr), .status_wdata(status_wdata),
        .debug_status_low(debug_status_low), .host_data(host_data), .long_ack(long_ack));
    dlef_bus_model bus (.clk(clk), .nrst(nrst), .stall(stall), .ecc_inj(ecc_inj), .data(data),
        .acc_go(acc_go), .bus_free(bus_free), .acc_done(acc_done), .ecc_error(ecc_error), .rd_data(rd_data));
    function automatic logic [7:0] flags(input logic o, input logic n, input logic r);
        return {3'b000, o, n, r, 2'b00};
    endfunction
    function automatic logic [7:0] exp_data(input logic n, input logic [7:0] d);
        return n ? SUBST_BYTE : d;
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (n_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Start an access, then wait for its end or abort
    task automatic access(input logic st, input logic ecc, input logic [7:0] d);
        stall <= st;
        ecc_inj <= ecc;
        data <= d;
        acc_req <= 1'b1;
        tick(1);
        acc_req <= 1'b0;
        for (k = 0; k < 600 && !acc_done && !acc_abort; k++)
            tick(1);
        tick(1);
        stall <= 1'b0;
        #1;
    endtask
    task automatic clear(input logic [7:0] v);
        status_wr <= 1'b1;
        status_wdata <= v;
        tick(1);
        status_wr <= 1'b0;
        tick(1);
        #1;
    endtask
    task automatic command();
        cmd_start <= 1'b1;
        tick(1);
        cmd_start <= 1'b0;
        tick(1);
        #1;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            stop_test();
        end
    end
    initial
    begin
        tick(8);
        nrst <= 1'b1;
        tick(2);
        riv = 1'b0;
        for (int i = 0; i < 12; i++)
        begin
            seed = xorshift(seed);
            access(1'b0, seed[9], seed[7:0]);
            riv = riv | seed[9];
            check("read data", host_data, seed[7:0]);
            check("status", debug_status_low, flags(0, 0, riv));
            if (seed[12])
            begin
                clear(8'h04);
                riv = 1'b0;
                check("riv clear", debug_status_low, flags(0, 0, 0));
            end
        end
        access(1'b1, 1'b0, 8'h3c);
        check("timeout span", 8'(k >= 508 && k <= 514), 8'h01);
        check("timeout data", host_data, exp_data(1, 8'h3c));
        check("nrs set", debug_status_low, flags(0, 1, riv));
        access(1'b0, 1'b1, 8'h81);
        check("nrs sticky", debug_status_low, flags(0, 1, 1));
        clear(8'h08);
        check("nrs only", debug_status_low, flags(0, 0, 1));
        clear(8'h14);
        check("ovr not writable", debug_status_low, flags(0, 0, 0));
        stall <= 1'b1;
        acc_req <= 1'b1;
        tick(1);
        acc_req <= 1'b0;
        tick(3);
        cmd_start <= 1'b1;
        tick(1);
        cmd_start <= 1'b0;
        stall <= 1'b0;
        tick(4);
        check("overrun", {4'h0, debug_status_low[7:4]}, 8'h01);
        check("long ack cmd", {7'h00, long_ack}, 8'h01);
        acc_req <= 1'b1;
        tick(1);
        acc_req <= 1'b0;
        for (k = 0; k < 20; k++)
        begin
            tick(1);
            check("suppressed", {7'h0, acc_go}, 8'h00);
        end
        clear(8'h10);
        check("ovr held", {7'h00, debug_status_low[4]}, 8'h01);
        resync_pulse <= 1'b1;
        tick(1);
        resync_pulse <= 1'b0;
        tick(1);
        #1;
        check("resync", {7'h00, debug_status_low[4]}, 8'h00);
        clear(8'h0c);
        stop_mode <= 1'b1;
        cmd_is_mem <= 1'b1;
        acc_req <= 1'b1;
        tick(1);
        acc_req <= 1'b0;
        tick(2);
        #1;
        check("stop block", {7'h00, debug_status_low[3]}, 8'h01);
        stop_mode <= 1'b0;
        cmd_is_mem <= 1'b0;
        clear(8'h08);
        wait_return_pending <= 1'b1;
        cmd_start <= 1'b1;
        tick(1);
        cmd_start <= 1'b0;
        wait_return_pending <= 1'b0;
        tick(2);
        #1;
        check("wait return", {7'h00, debug_status_low[3]}, 8'h01);
        // Edge-caused overrun waits a whole byte before long acknowledges
        host_pin_low <= 1'b1;
        ack_pending <= 1'b1;
        tick(1);
        host_pin_low <= 1'b0;
        ack_pending <= 1'b0;
        tick(1);
        #1;
        check("edge overrun", {7'h00, debug_status_low[4]}, 8'h01);
        check("long ack early", {7'h00, long_ack}, 8'h00);
        byte_received <= 1'b1;
        tick(1);
        byte_received <= 1'b0;
        tick(1);
        #1;
        check("long ack", {7'h00, long_ack}, 8'h01);
        resync_pulse <= 1'b1;
        tick(1);
        resync_pulse <= 1'b0;
        tick(1);
        #1;
        check("long ack off", {7'h00, long_ack}, 8'h00);
        // Immediate mode: retrieval before completion, abort held by stretch
        clear(8'h0c);
        ack_enable <= 1'b0;
        stall <= 1'b1;
        acc_req <= 1'b1;
        tick(1);
        acc_req <= 1'b0;
        ews <= 1'b1;
        tick(2);
        retrieve_start <= 1'b1;
        tick(1);
        retrieve_start <= 1'b0;
        tick(1);
        #1;
        check("retrieve nrs", {7'h00, debug_status_low[3]}, 8'h01);
        check("abort held", {6'h00, acc_abort, acc_go}, 8'h00);
        ews <= 1'b0;
        #1;
        check("abort released", {7'h00, acc_abort}, 8'h01);
        tick(1);
        #1;
        check("abort data", host_data, exp_data(1, 8'h00));
        check("abort idle", {7'h00, acc_go}, 8'h00);
        stall <= 1'b0;
        ack_enable <= 1'b1;
        // Wait mode: entry held off, register access and single step
        clear(8'h08);
        wait_mode <= 1'b1;
        cmd_is_enter_debug <= 1'b1;
        command();
        check("enter in wait", {6'h00, debug_status_low[3], enter_debug_req}, 8'h02);
        cmd_is_enter_debug <= 1'b0;
        clear(8'h08);
        cmd_is_cpu_reg <= 1'b1;
        command();
        check("reg in wait", {7'h00, debug_status_low[3]}, 8'h01);
        cmd_is_cpu_reg <= 1'b0;
        wait_mode <= 1'b0;
        #1;
        check("enter on exit", {7'h00, enter_debug_req}, 8'h01);
        tick(1);
        #1;
        check("enter done", {7'h00, enter_debug_req}, 8'h00);
        clear(8'h08);
        entering_wait <= 1'b1;
        cmd_is_step <= 1'b1;
        command();
        check("step into wait", {7'h00, debug_status_low[3]}, 8'h01);
        entering_wait <= 1'b0;
        cmd_is_step <= 1'b0;
        stop_test();
    end
endmodule // debug_link_error_flags_bench
`default_nettype wire

// File: verification/dlef_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module dlef_bus_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Bench knobs
    input wire logic stall,
    input wire logic ecc_inj,
    input wire logic [7:0] data,
    // Core bus side
    input wire logic acc_go,
    output logic bus_free,
    output logic acc_done,
    output logic ecc_error,
    output logic [7:0] rd_data
);
    assign bus_free = !stall;
    // Data not held outside a transfer, so a stale byte never passes
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            acc_done <= 1'b0;
            ecc_error <= 1'b0;
            rd_data <= 8'h5a;
        end
        else
        begin
            // Stall also holds off completion of a running access
            acc_done <= acc_go && !acc_done && !stall;
            ecc_error <= acc_go && !acc_done && !stall && ecc_inj;
            rd_data <= (acc_go && !acc_done && !stall) ? data : ~rd_data;
        end
    end
endmodule // dlef_bus_model
`default_nettype wire
